// ### rtl/gfcbs_regs.vh
`ifndef GFCBS_REGS_VH
`define GFCBS_REGS_VH
// fault response selections
`define GFCBS_RESP_IGNORE 2'h0
`define GFCBS_RESP_IMMED 2'h1
`define GFCBS_RESP_DELAY 2'h2
// restart selections
`define GFCBS_RST_NONE 2'h0
`define GFCBS_RST_LIMIT 2'h1
`define GFCBS_RST_CONT 2'h2
`define GFCBS_MAX_RETRY 4'he
// fault sequencer states
`define GFCBS_S_RUN 3'h0
`define GFCBS_S_GLITCH 3'h1
`define GFCBS_S_DELAY 3'h2
`define GFCBS_S_OFF 3'h3
`define GFCBS_S_WAIT 3'h4
`define GFCBS_S_LATCH 3'h5
// cold boot states
`define GFCBS_C_IDLE 2'h0
`define GFCBS_C_COLD 2'h1
`define GFCBS_C_DRAIN 2'h2
`define GFCBS_C_START 2'h3
`define GFCBS_C_NORM 2'h3
`define GFCBS_ZERO16 16'h0000
`define GFCBS_ONE16 16'h0001
`endif

// ### rtl/gfcbs_rail_enable.v
`include "gfcbs_regs.vh"
// one rail-enable pin: polarity and drive mode
module gfcbs_rail_enable (
	input wire clk,
	input wire sys_rst,
	input wire railOn,
	input wire activeLow,
	input wire openDrain,
	output reg pinOut_ff,
	output reg pinOe_ff
);
	wire level = railOn ^ activeLow;
	// released in reset so external resistors hold the supply off
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pinOut_ff <= 1'b0;
			pinOe_ff <= 1'b0; // see RQ22
		end else begin
			pinOut_ff <= level;
			pinOe_ff <= openDrain ? ~level : 1'b1; // see RQ21
		end
	end
endmodule // gfcbs_rail_enable

// ### rtl/gfcbs_sequencer.v
`include "gfcbs_regs.vh"
// Function
// RQ1: with fault enable set, input de-assert starts response; no retry offered. The code applies the restart modes to this fault.
// RQ2: glitch filter waits glitch time, responds only if fault persists.
// RQ3: responses are ignore, immediate shutdown, or shutdown after turn-off delay.
// RQ4: resequencing shuts affected and slave rails, waits, then resequences them.
// RQ5: no-restart keeps the output disabled until the fault clears.
// RQ6: limited restart retries up to programmed count capped at 14, spaced.
// RQ7: retries exhausted: output disabled until fault is cleared.
// RQ8: continuous restart retries until commanded off, bias loss, other fault.
// RQ9: debug input suppresses alert, fault response and logging of listed events.
// RQ10: debug sequences rails on timeout expiry only; zero timeout is immediate.
// RQ11: debug keeps fault bus released; affected logic outputs return to normal.
// RQ12: debug: de-asserted input neither logs nor responds, function still works.
// RQ13: fault-bus pin monitors the bus as an input when no fault exists.
// RQ14: local rail fault drives fault-bus pin low to inform peers.
// RQ15: after local fault clears, fault-bus pin returns to input.
// RQ16: cold boot entered at most once per reset; no watchdog reset then.
// RQ17: after reset sample thermal input; de-asserted enters cold boot and logs.
// RQ18: later thermal input changes create no log entries.
// RQ19: thermal-dependent rails stay off in cold boot, then power up.
// RQ20: on thermal assert or timeout, force cold rails off, wait, delay, ramp.
// RQ21: rail enables support polarity and open-drain or push-pull, up to 10.
// RQ22: in reset, general pins released; fast-PWM shared pins driven low.
// RQ23: fault-bus pin released when not pulling low, pull-up holds bus high.
module gfcbs_sequencer #(
	parameter NRAIL = 10,
	parameter NFAST = 8,
	parameter CW = 16
) (
	input wire clk,
	input wire sys_rst,
	input wire faultEnable,
	input wire generalInput,
	input wire glitchEnable,
	input wire [CW-1:0] glitchTime,
	input wire [1:0] response,
	input wire [CW-1:0] turnOffDelay,
	input wire reseqEnable,
	input wire [CW-1:0] reseqDelay,
	input wire [1:0] restartMode,
	input wire [3:0] restartCount,
	input wire [CW-1:0] restartInterval,
	input wire controlOff,
	input wire biasLost,
	input wire otherFault,
	input wire [NRAIL-1:0] faultRails,
	input wire [NRAIL-1:0] seqDepMet,
	input wire [NRAIL-1:0] seqOnReq,
	input wire [NRAIL-1:0] seqUpExpired,
	input wire [NRAIL-1:0] seqDownExpired,
	input wire [CW-1:0] seqTimeout,
	input wire debugInput,
	input wire railEventRaw,
	input wire alertRaw,
	input wire logEnable,
	input wire localRailFault,
	input wire faultBusIn,
	input wire watchdogRaw,
	input wire thermalInput,
	input wire [CW-1:0] coldTimeout,
	input wire [CW-1:0] normalStartDelay,
	input wire [NRAIL-1:0] coldRails,
	input wire [NRAIL-1:0] thermalDepRails,
	input wire [NRAIL-1:0] railBelowOff,
	input wire [NRAIL-1:0] enActiveLow,
	input wire [NRAIL-1:0] enOpenDrain,
	output reg faultBusOut_ff,
	output reg faultBusOe_ff,
	output reg faultBusSeen_ff,
	output reg alertOut_ff,
	output reg watchdogOut_ff,
	output reg logInputFault_ff,
	output reg logRailEvent_ff,
	output reg coldBootActive_ff,
	output reg retriesExhausted_ff,
	output reg [NFAST-1:0] fastPwmPin_ff,
	output wire [NRAIL-1:0] railEnPin,
	output wire [NRAIL-1:0] railEnOe
);
	reg [2:0] state_ff, nxt_state;
	reg [CW-1:0] cnt_ff, nxt_cnt;
	reg [3:0] tries_ff, nxt_tries;
	reg faultOff_ff, nxt_faultOff;
	reg [1:0] cbState_ff, nxt_cbState;
	reg [CW-1:0] cbCnt_ff, nxt_cbCnt;
	reg cbDone_ff;
	reg [NRAIL-1:0] railOn_ff, nxt_railOn;
	reg [NRAIL-1:0] dbgOn_ff, nxt_dbgOn;
	reg inPrev_ff;
	reg entryLog;
	wire inFault = faultEnable & ~generalInput & ~debugInput; // see RQ12
	wire stopRetry = controlOff | biasLost | otherFault; // see RQ8
	wire [3:0] limit = (restartCount > `GFCBS_MAX_RETRY) ? `GFCBS_MAX_RETRY : restartCount;
	wire cntDone = (cnt_ff == `GFCBS_ZERO16);
	// fault response sequencer
	always @* begin
		nxt_state = state_ff;
		nxt_cnt = cntDone ? cnt_ff : cnt_ff - `GFCBS_ONE16;
		nxt_tries = tries_ff;
		nxt_faultOff = faultOff_ff;
		case (state_ff)
		`GFCBS_S_RUN: begin
			if (inFault) begin // see RQ1
				if (glitchEnable) begin
					nxt_state = `GFCBS_S_GLITCH;
					nxt_cnt = glitchTime; // see RQ2
				end else if (response == `GFCBS_RESP_IMMED) begin
					nxt_state = `GFCBS_S_OFF; // see RQ3
				end else if (response == `GFCBS_RESP_DELAY) begin
					nxt_state = `GFCBS_S_DELAY;
					nxt_cnt = turnOffDelay; // see RQ3
				end
			end
		end
		`GFCBS_S_GLITCH: begin
			if (!inFault) begin
				nxt_state = `GFCBS_S_RUN; // see RQ2
			end else if (cntDone) begin
				if (response == `GFCBS_RESP_IMMED) begin
					nxt_state = `GFCBS_S_OFF;
				end else if (response == `GFCBS_RESP_DELAY) begin
					nxt_state = `GFCBS_S_DELAY;
					nxt_cnt = turnOffDelay;
				end else begin
					nxt_state = `GFCBS_S_LATCH; // ignore: hold here until input clears
				end
			end
		end
		`GFCBS_S_DELAY: begin
			if (cntDone) begin
				nxt_state = `GFCBS_S_OFF; // see RQ3
			end
		end
		`GFCBS_S_OFF: begin
			nxt_faultOff = 1'b1;
			if (reseqEnable) begin
				nxt_state = `GFCBS_S_WAIT;
				nxt_cnt = reseqDelay; // see RQ4
			end else if (restartMode == `GFCBS_RST_NONE) begin
				nxt_state = `GFCBS_S_LATCH; // see RQ5
			end else if (stopRetry) begin
				nxt_state = `GFCBS_S_LATCH; // see RQ8
			end else if (restartMode == `GFCBS_RST_LIMIT && tries_ff >= limit) begin
				nxt_state = `GFCBS_S_LATCH; // see RQ7
			end else begin
				nxt_state = `GFCBS_S_WAIT;
				nxt_cnt = restartInterval; // see RQ6
				nxt_tries = tries_ff + 4'h1;
			end
		end
		`GFCBS_S_WAIT: begin
			if (stopRetry && restartMode == `GFCBS_RST_CONT) begin
				nxt_state = `GFCBS_S_LATCH; // see RQ8
			end else if (cntDone) begin
				nxt_faultOff = 1'b0; // resequence the shut rails
				nxt_state = `GFCBS_S_RUN; // see RQ4
			end
		end
		default: begin
			// latched off; ignore path also lands here
			if (!inFault) begin
				nxt_state = `GFCBS_S_RUN; // see RQ5
				nxt_faultOff = 1'b0;
				nxt_tries = 4'h0;
			end
		end
		endcase
	end
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_ff <= `GFCBS_S_RUN;
			cnt_ff <= `GFCBS_ZERO16;
			tries_ff <= 4'h0;
			faultOff_ff <= 1'b0;
			retriesExhausted_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			tries_ff <= nxt_tries;
			faultOff_ff <= nxt_faultOff;
			retriesExhausted_ff <= (nxt_state == `GFCBS_S_LATCH) & nxt_faultOff; // see RQ7
		end
	end
	// cold boot: sampled once on the first cycle out of reset
	wire thermalGo = thermalInput | (cbCnt_ff == `GFCBS_ZERO16);
	always @* begin
		nxt_cbState = cbState_ff;
		nxt_cbCnt = (cbCnt_ff == `GFCBS_ZERO16) ? cbCnt_ff : cbCnt_ff - `GFCBS_ONE16;
		entryLog = 1'b0;
		case (cbState_ff)
		`GFCBS_C_IDLE: begin
			if (!cbDone_ff) begin
				if (!thermalInput) begin
					nxt_cbState = `GFCBS_C_COLD; // see RQ17
					nxt_cbCnt = coldTimeout;
					entryLog = logEnable;
				end else begin
					nxt_cbState = `GFCBS_C_NORM;
					nxt_cbCnt = `GFCBS_ZERO16;
				end
			end
		end
		`GFCBS_C_COLD: begin
			if (thermalGo) begin
				nxt_cbState = `GFCBS_C_DRAIN; // see RQ20
			end
		end
		`GFCBS_C_DRAIN: begin
			if ((railBelowOff & coldRails) == coldRails) begin
				nxt_cbState = `GFCBS_C_START; // see RQ20
				nxt_cbCnt = normalStartDelay;
			end
		end
		default: begin
			nxt_cbCnt = (cbCnt_ff == `GFCBS_ZERO16) ? cbCnt_ff : cbCnt_ff - `GFCBS_ONE16;
		end
		endcase
	end
	wire cbRamped = (cbState_ff == `GFCBS_C_NORM) && (cbCnt_ff == `GFCBS_ZERO16);
	wire effSeq = ~debugInput;
	// rail targets
	integer i;
	always @* begin
		for (i = 0; i < NRAIL; i = i + 1) begin
			nxt_dbgOn[i] = dbgOn_ff[i];
			// debug: dependencies ignored, follow timeout expiry only
			if (seqOnReq[i] & (seqUpExpired[i] | (seqTimeout == `GFCBS_ZERO16))) begin
				nxt_dbgOn[i] = 1'b1; // see RQ10
			end else if (~seqOnReq[i] & (seqDownExpired[i] | (seqTimeout == `GFCBS_ZERO16))) begin
				nxt_dbgOn[i] = 1'b0; // see RQ10
			end
			if (!effSeq) begin
				nxt_railOn[i] = dbgOn_ff[i];
			end else begin
				nxt_railOn[i] = seqOnReq[i] & seqDepMet[i];
			end
			if (faultOff_ff & faultRails[i] & effSeq) begin
				nxt_railOn[i] = 1'b0; // see RQ4
			end
			if (cbState_ff == `GFCBS_C_COLD && thermalDepRails[i]) begin
				nxt_railOn[i] = 1'b0; // see RQ19
			end
			// dependent rails wait for the ramp as well, not only the cold ones
			if (cbState_ff == `GFCBS_C_DRAIN && (coldRails[i] | thermalDepRails[i])) begin
				nxt_railOn[i] = 1'b0; // see RQ20
			end
			if (cbState_ff == `GFCBS_C_IDLE || (cbState_ff == `GFCBS_C_NORM && !cbRamped)) begin
				nxt_railOn[i] = 1'b0; // see RQ20
			end
		end
	end
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cbState_ff <= `GFCBS_C_IDLE;
			cbCnt_ff <= `GFCBS_ZERO16;
			cbDone_ff <= 1'b0;
			coldBootActive_ff <= 1'b0;
			logInputFault_ff <= 1'b0;
			railOn_ff <= {NRAIL{1'b0}};
			dbgOn_ff <= {NRAIL{1'b0}};
			inPrev_ff <= 1'b1;
		end else begin
			cbState_ff <= nxt_cbState;
			cbCnt_ff <= nxt_cbCnt;
			cbDone_ff <= 1'b1; // see RQ16
			coldBootActive_ff <= (nxt_cbState == `GFCBS_C_COLD);
			inPrev_ff <= generalInput;
			// only the entry sample logs; later thermal edges never do
			logInputFault_ff <= entryLog | (inFault & inPrev_ff & logEnable); // see RQ18
			railOn_ff <= nxt_railOn;
			dbgOn_ff <= nxt_dbgOn;
		end
	end
	// alert, logging, watchdog and fault bus
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			alertOut_ff <= 1'b0;
			logRailEvent_ff <= 1'b0;
			watchdogOut_ff <= 1'b0;
			faultBusOut_ff <= 1'b0;
			faultBusOe_ff <= 1'b0;
			faultBusSeen_ff <= 1'b0;
			fastPwmPin_ff <= {NFAST{1'b0}}; // see RQ22
		end else begin
			alertOut_ff <= alertRaw & ~debugInput; // see RQ9
			logRailEvent_ff <= railEventRaw & logEnable & ~debugInput; // see RQ9
			// next state, so the first cold cycle is quiet as well
			watchdogOut_ff <= watchdogRaw & ~debugInput & (nxt_cbState != `GFCBS_C_COLD); // see RQ16
			faultBusOut_ff <= 1'b0; // open drain: only ever drives low, see RQ23
			faultBusOe_ff <= faultEnable & localRailFault & ~debugInput; // see RQ14 RQ11 RQ15
			faultBusSeen_ff <= faultEnable & ~faultBusIn; // see RQ13
			fastPwmPin_ff <= {NFAST{1'b0}};
		end
	end
	genvar g;
	generate
		for (g = 0; g < NRAIL; g = g + 1) begin : gRail
			gfcbs_rail_enable uEn (
				.clk(clk),
				.sys_rst(sys_rst),
				.railOn(railOn_ff[g]),
				.activeLow(enActiveLow[g]),
				.openDrain(enOpenDrain[g]),
				.pinOut_ff(railEnPin[g]),
				.pinOe_ff(railEnOe[g])
			); // see RQ21
		end
	endgenerate
endmodule // gfcbs_sequencer

// ### dv/gfcbs_partner.sv
// far side: shared fault bus with pull-up, one peer, and the enabled rails
module gfcbs_partner (
	input wire logic clk,
	input wire logic faultBusOe_ff,
	input wire logic peerPull,
	output wire logic faultBusIn,
	input wire logic [9:0] railEnPin,
	input wire logic [9:0] railEnOe,
	input wire logic [9:0] enActiveLow,
	input wire logic [9:0] enOpenDrain,
	output logic [9:0] railBelowOff
);
	timeunit 1ns;
	timeprecision 1ns;
	// wired low: any driver wins, the pull-up holds it high otherwise
	assign faultBusIn = !(faultBusOe_ff || peerPull);
	// released push-pull line rests at its off resistor, released open-drain line at its pull-up
	wire [9:0] enLevel = (railEnOe & railEnPin) | (~railEnOe & (enOpenDrain | enActiveLow));
	// a rail decays one cycle after its enable goes inactive
	always @(posedge clk) begin
		railBelowOff <= ~(enLevel ^ enActiveLow);
	end
endmodule // gfcbs_partner

// ### dv/gfcbs_sequencer_asserts.sv
module gfcbs_sequencer_asserts #(
	parameter NFAST = 8
) (
	input wire clk,
	input wire sys_rst,
	input wire debugInput,
	input wire faultEnable,
	input wire localRailFault,
	input wire faultBusOe_ff,
	input wire faultBusOut_ff,
	input wire alertOut_ff,
	input wire logRailEvent_ff,
	input wire watchdogOut_ff,
	input wire coldBootActive_ff,
	input wire [NFAST-1:0] fastPwmPin_ff
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// once cold boot ends it must not come back for the next 8 cycles
	sequence s_stayNorm;
		!coldBootActive_ff [*8];
	endsequence
	a_dbg_no_alert: assert property (debugInput |=> !alertOut_ff) else $error("alert in debug");
	a_dbg_no_log: assert property (debugInput |=> !logRailEvent_ff) else $error("log in debug");
	a_dbg_bus_free: assert property (debugInput |=> !faultBusOe_ff) else $error("bus pulled in debug");
	a_bus_pull_low: assert property (faultEnable && localRailFault && !debugInput |=> faultBusOe_ff) else $error("bus not pulled");
	a_bus_level_low: assert property (faultBusOe_ff |-> !faultBusOut_ff) else $error("bus driven high");
	a_bus_release: assert property (!localRailFault |=> !faultBusOe_ff) else $error("bus not released");
	a_cold_no_wdog: assert property (coldBootActive_ff |-> !watchdogOut_ff) else $error("watchdog in cold boot");
	a_cold_once: assert property ($fell(coldBootActive_ff) |=> s_stayNorm) else $error("cold boot re-entered");
	a_pwm_pins_low: assert property (fastPwmPin_ff == '0) else $error("fast pins not low");
endmodule // gfcbs_sequencer_asserts
bind gfcbs_sequencer gfcbs_sequencer_asserts #(.NFAST(NFAST)) i_gfcbs_sequencer_asserts (.*);

// ### dv/gfcbs_tb.sv
`include "gfcbs_regs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, sys_rst = 1, faultEnable = 1, generalInput = 1, glitchEnable = 1;
	logic [15:0] glitchTime = 16'h0010, turnOffDelay = 16'h0008, reseqDelay = 16'h0008;
	logic [15:0] restartInterval = 16'h0008, seqTimeout = 16'h0000, coldTimeout = 16'h0400;
	logic [15:0] normalStartDelay = 16'h0004;
	logic [1:0] response = `GFCBS_RESP_IMMED, restartMode = `GFCBS_RST_NONE;
	logic [3:0] restartCount = 4'h2;
	logic reseqEnable = 0, controlOff = 0, biasLost = 0, otherFault = 0, debugInput = 0;
	logic railEventRaw = 0, alertRaw = 0, logEnable = 1, localRailFault = 0, watchdogRaw = 0;
	logic thermalInput = 0, peerPull = 0;
	logic [9:0] faultRails = 10'h003, seqDepMet = 10'h3ff, seqOnReq = 10'h3ff;
	logic [9:0] seqUpExpired = 10'h000, seqDownExpired = 10'h000, coldRails = 10'h010;
	logic [9:0] thermalDepRails = 10'h3ef, enActiveLow = 10'h005, enOpenDrain = 10'h000;
	wire faultBusIn, faultBusOut_ff, faultBusOe_ff, faultBusSeen_ff, alertOut_ff;
	wire watchdogOut_ff, logInputFault_ff, logRailEvent_ff, coldBootActive_ff;
	wire retriesExhausted_ff;
	wire [7:0] fastPwmPin_ff;
	wire [9:0] railEnPin, railEnOe, railBelowOff;
	int n_mismatch = 0, cmp_count = 0, logCnt = 0, rstCnt = 0, rstBase = 0;
	logic prevEn1 = 0;
	gfcbs_sequencer i_gfcbs_sequencer (.*);
	gfcbs_partner i_gfcbs_partner (.*);
	always #20 clk = ~clk;
	// log pulses are one cycle wide, so count them as they pass
	always @(posedge clk) begin
		if (logInputFault_ff === 1'b1) logCnt <= logCnt + 1;
	end
	// each rise of rail 1 (active high) marks one power-up attempt
	always @(posedge clk) begin
		prevEn1 <= railEnPin[1];
		if (prevEn1 === 1'b0 && railEnPin[1] === 1'b1) rstCnt <= rstCnt + 1;
	end
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task end_sim;
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#400000;
		n_mismatch++;
		end_sim();
	end
	initial begin
		cyc(10);
		chk("pwm", 10'h000, {2'h0, fastPwmPin_ff});
		chk("enOe", 10'h000, railEnOe);
		chk("busOe", 10'h000, faultBusOe_ff);
		cyc(10);
		sys_rst <= 0;
		watchdogRaw <= 1;
		cyc(2);
		chk("wdog", 0, watchdogOut_ff);
		cyc(2);
		chk("cold", 1, coldBootActive_ff);
		chk("log", 1, logCnt[9:0]);
		chk("wdog", 0, watchdogOut_ff);
		watchdogRaw <= 0;
		thermalInput <= 1;
		cyc(60);
		chk("cold", 0, coldBootActive_ff);
		chk("log", 1, logCnt[9:0]);
		chk("rails", 10'h3fa, railEnPin);
		chk("enOe", 10'h3ff, railEnOe);
		// a dip shorter than the filter must pass unnoticed
		generalInput <= 0;
		cyc(5);
		generalInput <= 1;
		cyc(20);
		chk("off", 0, retriesExhausted_ff);
		glitchEnable <= 0;
		generalInput <= 0;
		cyc(6);
		chk("off", 1, retriesExhausted_ff);
		cyc(30);
		chk("rails", 10'h3f9, railEnPin);
		localRailFault <= 1;
		cyc(3);
		chk("busOe", 1, faultBusOe_ff);
		chk("busLvl", 0, faultBusIn);
		localRailFault <= 0;
		cyc(3);
		chk("busOe", 0, faultBusOe_ff);
		peerPull <= 1;
		cyc(3);
		chk("busSeen", 1, faultBusSeen_ff);
		peerPull <= 0;
		debugInput <= 1;
		seqDepMet <= 10'h000;
		localRailFault <= 1;
		alertRaw <= 1;
		railEventRaw <= 1;
		cyc(3);
		chk("busOe", 0, faultBusOe_ff);
		chk("alert", 0, alertOut_ff);
		chk("railLog", 0, logRailEvent_ff);
		chk("rails", 10'h3fa, railEnPin);
		debugInput <= 0;
		seqDepMet <= 10'h3ff;
		cyc(3);
		chk("alert", 1, alertOut_ff);
		// limited restart: two attempts, then latched off
		generalInput <= 1;
		restartMode <= `GFCBS_RST_LIMIT;
		localRailFault <= 0;
		alertRaw <= 0;
		railEventRaw <= 0;
		cyc(5);
		rstBase = rstCnt;
		generalInput <= 0;
		cyc(20);
		chk("off", 0, retriesExhausted_ff);
		cyc(20);
		chk("restarts", 2, rstCnt - rstBase);
		chk("off", 1, retriesExhausted_ff);
		chk("rail1", 0, railEnPin[1]);
		// continuous restart runs past that count until commanded off
		generalInput <= 1;
		restartMode <= `GFCBS_RST_CONT;
		cyc(5);
		rstBase = rstCnt;
		generalInput <= 0;
		cyc(40);
		chk("off", 0, retriesExhausted_ff);
		chk("moreTries", 1, rstCnt - rstBase > 2);
		controlOff <= 1;
		cyc(10);
		chk("off", 1, retriesExhausted_ff);
		chk("rail1", 0, railEnPin[1]);
		controlOff <= 0;
		// warm start after a second reset goes straight to normal mode
		sys_rst <= 1;
		cyc(3);
		sys_rst <= 0;
		cyc(4);
		chk("cold", 0, coldBootActive_ff);
		end_sim();
	end
endmodule // tb
